// >>> design/psc_top.sv
// Pin-state control: drive level and enable of the multi-function pins.
// Assumes mode, power state and enable bits come from same-clock logic.
`timescale 1ns/1ps
`include "psc_consts.svh"
module psc_top (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic external_rst_n_in,
  input wire logic [`PSC_MODE_W-1:0] mode_in,
  input wire psc_pkg::psc_state_t state_in,
  input wire psc_pkg::psc_phase_t phase_in,
  input wire logic two_state_area_in,
  input wire logic watchdog_timer_rst_in,
  input wire logic bus_release_enable_bit_in,
  input wire logic refresh_pin_enable_bit_in,
  input wire logic [3:0] cs_dir_in,
  input wire logic [`PSC_UPPER_W-1:0] upper_cs_sel_in,
  input wire logic [`PSC_UPPER_W-1:0] upper_addr_sel_in,
  input wire logic bus_grant_req_in,
  input wire logic refresh_sig_in,
  input wire logic [`PSC_ADDR_W-1:0] addr_run_in,
  input wire psc_pkg::psc_strobes_t strobes_run_in,
  input wire logic data_oe_run_in,
  input wire logic [7:0] port_dir_run_in,
  output logic rst_low_out,
  output psc_pkg::psc_pin_t rst_out_n_out,
  output psc_pkg::psc_pin_t refresh_strobe_n_out,
  output psc_pkg::psc_pin_t bus_request_in_n_out,
  output psc_pkg::psc_pin_t bus_grant_n_out,
  output psc_pkg::psc_pin_t [3:0] cs_out,
  output psc_pkg::psc_pin_t [`PSC_UPPER_W-1:0] upper_out,
  output psc_pkg::psc_strobes_t strobes_out,
  output logic [`PSC_ADDR_W-1:0] addr_out,
  output logic addr_oe_out,
  output logic data_oe_out,
  output logic [7:0] port_dir_out,
  output logic bus_released_out
);
  import psc_pkg::*;

  logic ext_low;
  logic ext_low_prev_q, ext_low_prev_d;
  logic [`PSC_ADDR_W-1:0] addr_q, addr_d;
  logic addr_hold_q, addr_hold_d;
  logic bus_mode, single_mode, upper_mode, normal;
  logic [6:0] hold_lvl, hold_oe, keep_lvl, keep_oe;

  // Resynchronised reset pin, falling edge
  psc_rst_sampler u_sampler (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .external_rst_n_in(external_rst_n_in),
    .rst_low_out(ext_low)
  );
  // Synced reset level is also visible at the pins
  assign rst_low_out = ext_low;

  // Mode classes
  assign single_mode = (mode_in == `PSC_MODE_SINGLE);
  assign bus_mode = (mode_in >= `PSC_MODE_MIN) && !single_mode;
  assign upper_mode = (mode_in == `PSC_MODE_UPPER_A) || (mode_in == `PSC_MODE_UPPER_B) ||
                      (mode_in == `PSC_MODE_UPPER_C);
  assign normal = (state_in == PSC_RUN);

  // Levels captured for keep: bit 0 refresh, 1 request, 2 grant, 3..5 upper, 6 cs0
  always_comb begin
    hold_lvl = {cs_out[0].lvl, upper_out[2].lvl, upper_out[1].lvl, upper_out[0].lvl,
                bus_grant_n_out.lvl, bus_request_in_n_out.lvl, refresh_strobe_n_out.lvl};
    hold_oe = {cs_out[0].oe, upper_out[2].oe, upper_out[1].oe, upper_out[0].oe,
               bus_grant_n_out.oe, bus_request_in_n_out.oe, refresh_strobe_n_out.oe};
  end

  // Keep store refreshed only while running, frozen in other states
  psc_hold_bank #(.W(7)) u_hold (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .cap_in(normal && !ext_low),
    .lvl_in(hold_lvl),
    .oe_in(hold_oe),
    .lvl_out(keep_lvl),
    .oe_out(keep_oe)
  );

  // Address hold or clear after a sampled reset
  always_comb begin
    ext_low_prev_d = ext_low;
    addr_hold_d = addr_hold_q;
    addr_d = addr_q;
    if (!ext_low) begin
      addr_d = addr_run_in;
      addr_hold_d = 1'b0;
    end else if (!ext_low_prev_q) begin
      if (phase_in == PSC_T3 || (phase_in == PSC_T2 && two_state_area_in)) begin
        addr_hold_d = 1'b1;
      end else begin
        addr_d = `PSC_ADDR_LOW;
        addr_hold_d = 1'b0;
      end
    end else begin
      // Held address ends with its state, then clears
      addr_d = `PSC_ADDR_LOW;
      addr_hold_d = 1'b0;
    end
  end
  // Falling edge gives a one-clock delay after the sampled reset rises
  always_ff @(negedge clk_in) begin
    if (rst_in) begin
      ext_low_prev_q <= 1'b0;
      addr_q <= `PSC_ADDR_LOW;
      addr_hold_q <= 1'b0;
    end else begin
      ext_low_prev_q <= ext_low_prev_d;
      addr_q <= addr_d;
      addr_hold_q <= addr_hold_d;
    end
  end

  always_comb begin
    rst_out_n_out = '{lvl: 1'b1, oe: 1'b0};
    refresh_strobe_n_out = '{lvl: 1'b1, oe: 1'b0};
    bus_request_in_n_out = '{lvl: 1'b1, oe: 1'b0};
    bus_grant_n_out = '{lvl: 1'b1, oe: 1'b0};
    cs_out = '0;
    upper_out = '0;
    strobes_out = strobes_run_in;
    addr_out = addr_run_in;
    addr_oe_out = bus_mode;
    data_oe_out = data_oe_run_in;
    port_dir_out = port_dir_run_in;
    bus_released_out = 1'b0;
    if (watchdog_timer_rst_in) begin
      rst_out_n_out = '{lvl: 1'b0, oe: 1'b1};
    end
    bus_released_out = bus_mode && (state_in == PSC_BUS_REL);
    if (ext_low || state_in == PSC_RESET) begin
      port_dir_out = '0;
      strobes_out = '{'{1'b1, bus_mode}, '{1'b1, bus_mode}, '{1'b1, bus_mode},
                      '{1'b1, bus_mode}};
      data_oe_out = 1'b0;
      addr_out = addr_q;
      addr_oe_out = bus_mode;
      // chip select 0 low in reset
      if (bus_mode) begin
        cs_out[0] = '{lvl: 1'b0, oe: 1'b1};
      end
    end else if (state_in == PSC_HW_STBY) begin
      strobes_out = '0;
      addr_oe_out = 1'b0;
      data_oe_out = 1'b0;
      port_dir_out = '0;
    end else if (bus_mode && (state_in == PSC_SW_STBY || state_in == PSC_BUS_REL)) begin
      strobes_out = '0;
      addr_oe_out = 1'b0;
      data_oe_out = 1'b0;
      if (state_in == PSC_SW_STBY) begin
        refresh_strobe_n_out = '{lvl: refresh_sig_in, oe: 1'b1};
        bus_request_in_n_out = bus_release_enable_bit_in ? psc_pin_t'{1'b1, 1'b0}
                                                         : psc_pin_t'{keep_lvl[1], keep_oe[1]};
        bus_grant_n_out = bus_release_enable_bit_in ? psc_pin_t'{1'b1, 1'b1}
                                                    : psc_pin_t'{keep_lvl[2], keep_oe[2]};
        cs_out[0] = cs_dir_in[0] ? psc_pin_t'{1'b0, 1'b1} : psc_pin_t'{1'b1, 1'b0};
      end else begin
        refresh_strobe_n_out = refresh_pin_enable_bit_in ? psc_pin_t'{1'b1, 1'b1}
                                                         : psc_pin_t'{keep_lvl[0], keep_oe[0]};
        bus_request_in_n_out = '{1'b1, 1'b0};
        bus_grant_n_out = '{1'b0, 1'b1};
        cs_out[0] = cs_dir_in[0] ? psc_pin_t'{1'b1, 1'b1}
                                 : psc_pin_t'{keep_lvl[6], keep_oe[6]};
      end
      for (int i = 1; i < 4; i++) begin
        cs_out[i] = cs_dir_in[i] ? psc_pin_t'{1'b1, 1'b1} : psc_pin_t'{1'b1, 1'b0};
      end
      if (upper_mode) begin
        for (int i = 0; i < `PSC_UPPER_W; i++) begin
          if (upper_cs_sel_in[i]) begin
            upper_out[i] = '{1'b1, 1'b1};
          end else if (upper_addr_sel_in[i]) begin
            upper_out[i] = '{1'b1, 1'b0};
          end else begin
            upper_out[i] = '{keep_lvl[3+i], keep_oe[3+i]};
          end
        end
      end
    end else if (normal && bus_mode) begin
      refresh_strobe_n_out = '{refresh_sig_in, refresh_pin_enable_bit_in};
      bus_grant_n_out = '{!bus_grant_req_in, bus_release_enable_bit_in};
      for (int i = 0; i < 4; i++) begin
        cs_out[i] = '{1'b1, cs_dir_in[i]};
      end
      for (int i = 0; i < `PSC_UPPER_W; i++) begin
        upper_out[i] = '{!upper_addr_sel_in[i], upper_cs_sel_in[i] || upper_addr_sel_in[i]};
      end
    end
  end

  // Assertions
  a_rst_dir_input: assert property (@(posedge clk_in) disable iff (rst_in)
    ext_low |-> port_dir_out == 8'h00 && !data_oe_out)
    else $error("ports not input during reset");
  a_strobe_high: assert property (@(posedge clk_in) disable iff (rst_in)
    (ext_low && bus_mode) |-> strobes_out.as_n.lvl && strobes_out.rd_n.lvl)
    else $error("strobes not high in reset");
  a_single_no_rel: assert property (@(posedge clk_in) disable iff (rst_in)
    single_mode |-> !bus_released_out)
    else $error("bus released in single-chip mode");
  a_rsto_wdt: assert property (@(posedge clk_in) disable iff (rst_in)
    rst_out_n_out.oe |-> watchdog_timer_rst_in)
    else $error("reset output driven without watchdog");
  a_grant_low_rel: assert property (@(posedge clk_in) disable iff (rst_in)
    bus_released_out && !ext_low |-> bus_grant_n_out == psc_pin_t'{1'b0, 1'b1})
    else $error("grant not low while released");
  a_req_float_rel: assert property (@(posedge clk_in) disable iff (rst_in)
    bus_released_out && !ext_low |-> !bus_request_in_n_out.oe)
    else $error("request driven while released");
  a_cs0_reset_low: assert property (@(posedge clk_in) disable iff (rst_in)
    (ext_low && bus_mode) |-> cs_out[0] == psc_pin_t'{1'b0, 1'b1})
    else $error("chip select 0 not low in reset");
  a_addr_clear: assert property (@(negedge clk_in) disable iff (rst_in)
    $rose(ext_low) && phase_in == PSC_T1 |=> addr_q == `PSC_ADDR_LOW)
    else $error("address not cleared after reset");
  // Held address must not move while the hold flag stands
  a_addr_held: assert property (@(negedge clk_in) disable iff (rst_in)
    addr_hold_q |-> addr_q == $past(addr_q))
    else $error("held address changed");
endmodule

// >>> common/psc_consts.svh
// Constants for the pin-state control block.
// Assumes inclusion by the package, design and bench files of this block only.
// What this block does
// - Held pins: inputs float, outputs keep their previous driven level.
// - Mode 7 never grants the bus; no bus-released state exists.
// - Reset output pulled low only for watchdog-overflow resets, else floats.
// - External reset low turns every port pin to input two falling edges later.
// - Reset during access: strobes high, data bus floats.
// - Reset in first state, or second state of three-state access: address low one clock after the sampled reset.
// - External reset is sampled on the falling clock edge.
// - Reset in third state of three-state access: address held that state.
// - Reset in second state of two-state access: address held likewise.
// - Reset in a wait state behaves as reset in second state.
// - Refresh pin: refresh in software standby; bus-release keeps or drives high.
// - Bus-request pin: keep or float in standby, floats when released.
// - Bus-grant pin: keep or high in software standby, low when released.
// - Chip selects 3..0 drive high when direction set, else input, except cs0 in standby; cs0 keeps instead when bus released.
// - Chip select 0 low in reset; software standby low if direction set.
// - Shared address/select pins: select high, address float, else keep.
`ifndef PSC_CONSTS_SVH
`define PSC_CONSTS_SVH
`define PSC_MODE_W 3
`define PSC_MODE_SINGLE 3'h7
`define PSC_MODE_MIN 3'h1
`define PSC_MODE_UPPER_A 3'h3
`define PSC_MODE_UPPER_B 3'h4
`define PSC_MODE_UPPER_C 3'h6
`define PSC_ADDR_W 24
`define PSC_DATA_W 16
`define PSC_CS_W 8
`define PSC_UPPER_W 3
`define PSC_ADDR_LOW 24'h000000
`endif

// >>> common/psc_pkg.sv
// Types shared by the pin-state control block.
// Assumes the constants header sits beside it.
`include "psc_consts.svh"
package psc_pkg;
  // Power and bus condition of the chip
  typedef enum logic [2:0] {
    PSC_RUN, PSC_RESET, PSC_HW_STBY, PSC_SW_STBY, PSC_BUS_REL
  } psc_state_t;
  // Bus cycle phase when reset may strike
  typedef enum logic [2:0] {
    PSC_IDLE, PSC_T1, PSC_T2, PSC_T3, PSC_TW
  } psc_phase_t;
  // One driven pin: level and enable
  typedef struct packed {
    logic lvl;
    logic oe;
  } psc_pin_t;
  // Bus strobes as a group
  typedef struct packed {
    psc_pin_t as_n;
    psc_pin_t rd_n;
    psc_pin_t upper_byte_write_n;
    psc_pin_t lower_byte_write_n;
  } psc_strobes_t;
endpackage

// >>> design/psc_rst_sampler.sv
// Samples the external reset pin on the falling clock edge.
// Assumes the pin is asynchronous; two falling-edge stages resync it.
`timescale 1ns/1ps
module psc_rst_sampler (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic external_rst_n_in,
  output logic rst_low_out
);
  import psc_pkg::*;
  logic s1_q, s1_d, s2_q, s2_d;
  // Next values for the two stages
  always_comb begin
    s1_d = external_rst_n_in;
    s2_d = s1_q;
  end
  always_ff @(negedge clk_in) begin
    if (rst_in) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
    end
  end
  assign rst_low_out = ~s2_q;
endmodule

// >>> design/psc_hold_bank.sv
// Remembers the last driven level of each held pin.
// Assumes a capture strobe from the parent while the pins run normally.
`timescale 1ns/1ps
module psc_hold_bank #(
  parameter int W = 8
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic cap_in,
  input wire logic [W-1:0] lvl_in,
  input wire logic [W-1:0] oe_in,
  output logic [W-1:0] lvl_out,
  output logic [W-1:0] oe_out
);
  import psc_pkg::*;
  logic [W-1:0] lvl_q, lvl_d, oe_q, oe_d;
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_comb begin
        lvl_d[g] = cap_in ? lvl_in[g] : lvl_q[g];
        oe_d[g] = cap_in ? oe_in[g] : oe_q[g];
      end
    end
  endgenerate
  // Registers only
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      lvl_q <= '0;
      oe_q <= '0;
    end else begin
      lvl_q <= lvl_d;
      oe_q <= oe_d;
    end
  end
  assign lvl_out = lvl_q;
  assign oe_out = oe_q;
endmodule

// >>> verification/psc_ext_mem.sv
// External memory stand-in: counts the write strobes that reach it.
// Assumes the strobe group comes straight from the pin-state block.
`timescale 1ns/1ps
module psc_ext_mem (
  input wire logic clk_in,
  input wire psc_pkg::psc_strobes_t strobes_in,
  output logic [15:0] wr_cnt_out
);
  import psc_pkg::*;
  // Only a driven low strobe writes; a floating pin must not count
  initial wr_cnt_out = 16'h0000;
  always @(posedge clk_in) begin
    if ((strobes_in.upper_byte_write_n === 2'b01) ||
        (strobes_in.lower_byte_write_n === 2'b01)) begin
      wr_cnt_out <= wr_cnt_out + 16'h0001;
    end
  end
endmodule

// >>> verification/pin_state_control_tb.sv
// Self-checking bench for the pin-state control block.
// Assumes a 200 MHz clock and inputs changed at the falling edge.
`timescale 1ns/1ps
`include "psc_consts.svh"
`define PSC_CHK(n, e, g) begin checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("mismatch %s exp %0h got %0h", n, e, g); end end
module pin_state_control_tb;
  import psc_pkg::*;
  typedef struct {logic [2:0] m; psc_state_t s; logic b, r, w; logic [3:0] d;
    logic [1:0] brq, bgr; logic rf; logic [1:0] c0, c1, as_n, ro, u0; logic rel;} psc_row_t;
  logic clk_in = 1'b0, rst_in = 1'b1, external_rst_n_in = 1'b1, two_state_area_in = 1'b0;
  logic [2:0] mode_in = 3'h1;
  psc_state_t state_in = PSC_RESET;
  psc_phase_t phase_in = PSC_IDLE;
  logic watchdog_timer_rst_in = 1'b0, bus_release_enable_bit_in = 1'b0;
  logic refresh_pin_enable_bit_in = 1'b0, bus_grant_req_in = 1'b0, refresh_sig_in = 1'b1;
  logic [3:0] cs_dir_in = 4'h0;
  logic [2:0] upper_cs_sel_in = 3'h1, upper_addr_sel_in = 3'h2;
  logic [23:0] addr_run_in = 24'hA5C33C;
  psc_strobes_t strobes_run_in = 8'h55;
  logic data_oe_run_in = 1'b1;
  logic [7:0] port_dir_run_in = 8'hFF, port_dir_out;
  logic rst_low_out, addr_oe_out, data_oe_out, bus_released_out;
  psc_pin_t rst_out_n_out, refresh_strobe_n_out, bus_request_in_n_out, bus_grant_n_out;
  psc_pin_t [3:0] cs_out;
  psc_pin_t [2:0] upper_out;
  psc_strobes_t strobes_out;
  logic [23:0] addr_out;
  logic [15:0] wr_cnt, wr_ref;
  int error_cnt = 0, checked = 0, cyc = 0;
  // Reset, standby and release rows; no run row first, so kept pins read cleared
  psc_row_t rows [8] = '{
    '{3'h1, PSC_RESET, 0, 0, 0, 4'h0, 0, 0, 0, 1, 0, 3, 0, 0, 0},
    '{3'h1, PSC_RESET, 0, 0, 1, 4'h0, 0, 0, 0, 1, 0, 3, 1, 0, 0},
    '{3'h2, PSC_HW_STBY, 1, 1, 0, 4'hF, 0, 0, 0, 0, 0, 0, 0, 0, 0},
    '{3'h1, PSC_SW_STBY, 0, 0, 0, 4'h0, 0, 0, 1, 0, 0, 0, 0, 0, 0},
    '{3'h5, PSC_SW_STBY, 1, 0, 0, 4'hF, 0, 3, 1, 1, 3, 0, 0, 0, 0},
    '{3'h3, PSC_SW_STBY, 1, 0, 0, 4'hF, 0, 3, 1, 1, 3, 0, 0, 3, 0},
    '{3'h1, PSC_BUS_REL, 1, 0, 0, 4'h0, 0, 1, 0, 0, 0, 0, 0, 0, 1},
    '{3'h6, PSC_BUS_REL, 1, 1, 0, 4'hF, 0, 1, 1, 3, 3, 0, 0, 3, 1}};
  psc_phase_t phs [5] = '{PSC_T1, PSC_T2, PSC_TW, PSC_T3, PSC_T2};
  logic [4:0] two_v = 5'b10000, hold_v = 5'b11000;

  psc_top psc_top_inst (.clk_in(clk_in), .rst_in(rst_in),
    .external_rst_n_in(external_rst_n_in), .mode_in(mode_in), .state_in(state_in),
    .phase_in(phase_in), .two_state_area_in(two_state_area_in),
    .watchdog_timer_rst_in(watchdog_timer_rst_in),
    .bus_release_enable_bit_in(bus_release_enable_bit_in),
    .refresh_pin_enable_bit_in(refresh_pin_enable_bit_in), .cs_dir_in(cs_dir_in),
    .upper_cs_sel_in(upper_cs_sel_in), .upper_addr_sel_in(upper_addr_sel_in),
    .bus_grant_req_in(bus_grant_req_in), .refresh_sig_in(refresh_sig_in),
    .addr_run_in(addr_run_in), .strobes_run_in(strobes_run_in),
    .data_oe_run_in(data_oe_run_in), .port_dir_run_in(port_dir_run_in),
    .rst_low_out(rst_low_out), .rst_out_n_out(rst_out_n_out),
    .refresh_strobe_n_out(refresh_strobe_n_out), .bus_request_in_n_out(bus_request_in_n_out),
    .bus_grant_n_out(bus_grant_n_out), .cs_out(cs_out), .upper_out(upper_out),
    .strobes_out(strobes_out), .addr_out(addr_out), .addr_oe_out(addr_oe_out),
    .data_oe_out(data_oe_out), .port_dir_out(port_dir_out),
    .bus_released_out(bus_released_out));
  psc_ext_mem psc_ext_mem_inst (.clk_in(clk_in), .strobes_in(strobes_out),
    .wr_cnt_out(wr_cnt));

  // Undriven pins read as zero so a floating level never matters
  function automatic logic [1:0] pv(psc_pin_t p);
    return p.oe ? p : 2'b00;
  endfunction

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  always #2.5 clk_in = ~clk_in;
  // Ceiling well above the roughly 70 cycles the tests need
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      wrap_up();
    end
  end

  initial begin
    repeat (10) @(posedge clk_in);
    @(negedge clk_in) rst_in <= 1'b0;
    // Pin table per mode, state and enable bits
    foreach (rows[i]) begin
      @(negedge clk_in);
      mode_in <= rows[i].m;
      state_in <= rows[i].s;
      bus_release_enable_bit_in <= rows[i].b;
      refresh_pin_enable_bit_in <= rows[i].r;
      watchdog_timer_rst_in <= rows[i].w;
      cs_dir_in <= rows[i].d;
      @(posedge clk_in) #1;
      `PSC_CHK("brq", rows[i].brq, pv(bus_request_in_n_out))
      `PSC_CHK("bgr", rows[i].bgr, pv(bus_grant_n_out))
      `PSC_CHK("refresh_strobe_n", rows[i].rf, refresh_strobe_n_out.oe)
      `PSC_CHK("cs0", rows[i].c0, pv(cs_out[0]))
      `PSC_CHK("cs1", rows[i].c1, pv(cs_out[1]))
      `PSC_CHK("as", rows[i].as_n, pv(strobes_out.as_n))
      `PSC_CHK("wr", rows[i].as_n, pv(strobes_out.lower_byte_write_n))
      `PSC_CHK("rsto", rows[i].ro, pv(rst_out_n_out))
      `PSC_CHK("up0", rows[i].u0, pv(upper_out[0]))
      `PSC_CHK("up1", 2'b00, pv(upper_out[1]))
      `PSC_CHK("rel", rows[i].rel, bus_released_out)
    end
    // Single-chip mode never shows a released bus
    @(negedge clk_in);
    mode_in <= 3'h7;
    @(posedge clk_in) #1;
    `PSC_CHK("rel7", 1'b0, bus_released_out)
    // Reset striking mid-access in each bus phase
    foreach (phs[i]) begin
      @(negedge clk_in);
      mode_in <= 3'h1;
      state_in <= PSC_RUN;
      phase_in <= phs[i];
      two_state_area_in <= two_v[i];
      @(negedge clk_in) #1;
      `PSC_CHK("dir_run", 8'hFF, port_dir_out)
      `PSC_CHK("rl_idle", 1'b0, rst_low_out)
      external_rst_n_in <= 1'b0;
      repeat (2) @(negedge clk_in);
      #1;
      wr_ref = wr_cnt;
      `PSC_CHK("rst_low", 1'b1, rst_low_out)
      `PSC_CHK("port_dir", 8'h00, port_dir_out)
      `PSC_CHK("as_rst", 2'b11, pv(strobes_out.as_n))
      `PSC_CHK("rd_rst", 2'b11, pv(strobes_out.rd_n))
      `PSC_CHK("uw_rst", 2'b11, pv(strobes_out.upper_byte_write_n))
      `PSC_CHK("data_oe", 1'b0, data_oe_out)
      @(negedge clk_in) #1;
      `PSC_CHK("addr_e3", hold_v[i] ? 24'hA5C33C : 24'h000000, addr_out)
      `PSC_CHK("addr_oe", 1'b1, addr_oe_out)
      @(negedge clk_in) #1;
      `PSC_CHK("addr_e4", 24'h000000, addr_out)
      `PSC_CHK("no_write", wr_ref, wr_cnt)
      external_rst_n_in <= 1'b1;
      repeat (3) @(negedge clk_in);
    end
    // Keep store: levels captured in run reappear in bus release
    @(negedge clk_in);
    mode_in <= 3'h5;
    state_in <= PSC_RUN;
    refresh_pin_enable_bit_in <= 1'b1;
    cs_dir_in <= 4'hF;
    @(negedge clk_in);
    state_in <= PSC_BUS_REL;
    refresh_pin_enable_bit_in <= 1'b0;
    cs_dir_in <= 4'h0;
    @(posedge clk_in) #1;
    `PSC_CHK("rf_keep", 2'b11, pv(refresh_strobe_n_out))
    `PSC_CHK("cs0_keep", 2'b11, pv(cs_out[0]))
    `PSC_CHK("bgr_rel", 2'b01, pv(bus_grant_n_out))
    `PSC_CHK("aoe_rel", 1'b0, addr_oe_out)
    wrap_up();
  end
endmodule
